//--- rtl/nvmbp_pkg.sv
/*
  Shared constants and carriers for the byte-wide data EEPROM programming
  controller. Assumes one 25 MHz clock and a synchronous active-high reset.
*/
package nvmbp_pkg;

  localparam int unsigned NVMBP_ADDR_W = 7;
  localparam int unsigned NVMBP_DATA_W = 8;
  localparam int unsigned NVMBP_DEPTH = 128;

  // Control register field positions.
  localparam int unsigned NVMBP_CTL_READ = 0;
  localparam int unsigned NVMBP_CTL_TRIG = 1;
  localparam int unsigned NVMBP_CTL_ARM = 2;
  localparam int unsigned NVMBP_CTL_MODE_LO = 4;

  // Programming modes.
  localparam logic [1:0] NVMBP_MODE_ATOMIC = 2'h0;
  localparam logic [1:0] NVMBP_MODE_ERASE = 2'h1;
  localparam logic [1:0] NVMBP_MODE_WRITE = 2'h2;
  localparam logic [1:0] NVMBP_MODE_RSVD = 2'h3;

  localparam logic [NVMBP_DATA_W-1:0] NVMBP_ERASED = 8'hff;
  localparam logic [NVMBP_DATA_W-1:0] NVMBP_DATA_RST = 8'h00;
  localparam logic [NVMBP_ADDR_W-1:0] NVMBP_ADDR_RST = 7'h00;

  // Arm window, read stall and write stall, all in CPU clock cycles.
  localparam int unsigned NVMBP_ARM_CYCLES = 4;
  localparam int unsigned NVMBP_READ_STALL = 4;
  localparam int unsigned NVMBP_WRITE_STALL = 2;

  // Programming times in microseconds.
  localparam int unsigned NVMBP_T_ATOMIC_US = 3400;
  localparam int unsigned NVMBP_T_SPLIT_US = 1800;

  // Software write bundle for the control register.
  typedef struct packed {
    logic read_strobe;
    logic program_trigger_busy;
    logic program_arm;
    logic mode_we;
    logic [1:0] program_mode_select;
  } nvmbp_ctl_wr_s;

  typedef enum logic [1:0] {
    NVMBP_IDLE,
    NVMBP_ERASE,
    NVMBP_PROG
  } nvmbp_state_e;

endpackage : nvmbp_pkg

//--- rtl/nvmbp_osc_tick.sv
/*
  Divider that models the calibrated internal oscillator as a one-cycle
  enable pulse derived from the CPU clock. Assumes the caller sets DIV so
  that the pulse rate equals the calibrated oscillator rate.
*/
module nvmbp_osc_tick #(
  parameter int unsigned DIV = 25
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Oscillator tick
  output logic tick
);

  localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic next_tick;

  initial begin
    if (DIV < 1) $error("nvmbp_osc_tick: DIV must be at least 1");
  end

  always_comb begin
    if (rst) begin
      next_cnt = '0;
      next_tick = 1'b0;
    end else if (cnt == CW'(DIV - 1)) begin
      next_cnt = '0;
      next_tick = 1'b1;
    end else begin
      next_cnt = cnt + CW'(1);
      next_tick = 1'b0;
    end
  end

  // Reset restarts the divider so its count is never left unknown. A busy
  // operation is stretched by the reset length plus up to one divider period and still completes.
  always_ff @(posedge clk) begin
    cnt <= next_cnt;
    tick <= next_tick;
  end

endmodule : nvmbp_osc_tick

//--- rtl/nvmbp_ctrl.sv
/*
  Byte-wide data EEPROM programming controller with its storage array.
  Software writes address, data and control through plain strobed ports.
  Assumes one CPU clock, a synchronous active-high reset, and that the
  oscillator divider produces ticks at the calibrated oscillator rate.
*/
module nvmbp_ctrl
  import nvmbp_pkg::*;
#(
  parameter int unsigned OSC_DIV = 25,
  parameter int unsigned OSC_MHZ = 1,
  parameter int unsigned T_ATOMIC = NVMBP_T_ATOMIC_US * OSC_MHZ,
  parameter int unsigned T_SPLIT = NVMBP_T_SPLIT_US * OSC_MHZ
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Address and data register writes
  input wire logic addr_we,
  input wire logic [NVMBP_ADDR_W-1:0] addr_wdata,
  input wire logic data_we,
  input wire logic [NVMBP_DATA_W-1:0] data_wdata,
  // Control register write
  input wire logic ctl_we,
  input wire nvmbp_ctl_wr_s ctl_wdata,
  // Register views and CPU stall
  output logic [NVMBP_ADDR_W-1:0] nvm_byte_address,
  output logic [NVMBP_DATA_W-1:0] nvm_byte_data,
  output logic [1:0] program_mode_select,
  output logic program_arm,
  output logic program_trigger_busy,
  output logic cpu_stall
);

  localparam int unsigned TW = $clog2(T_ATOMIC + 1);

  initial begin
    if (T_SPLIT < 1 || T_ATOMIC < T_SPLIT) $error("nvmbp_ctrl: bad times");
  end

  logic [NVMBP_DATA_W-1:0] mem [NVMBP_DEPTH];
  logic osc_tick;
  nvmbp_state_e state, next_state;
  logic [TW-1:0] tcnt, next_tcnt;
  logic [2:0] arm_cnt, next_arm_cnt;
  logic [2:0] stall_cnt, next_stall_cnt;
  logic [NVMBP_ADDR_W-1:0] next_addr;
  logic [NVMBP_DATA_W-1:0] next_data;
  logic [1:0] next_mode;
  logic next_arm, next_busy, next_stall;
  logic start, rd, mem_we;
  logic [NVMBP_DATA_W-1:0] mem_wval;

  nvmbp_osc_tick #(.DIV(OSC_DIV)) u_tick (
    .clk(clk),
    .rst(rst),
    .tick(osc_tick)
  );

  ////////////////////////////////////////////////////////////////////////////

  function automatic logic [TW-1:0] op_time(input logic [1:0] m);
    op_time = (m == NVMBP_MODE_ATOMIC) ? TW'(T_ATOMIC) : TW'(T_SPLIT);
  endfunction : op_time

  always_comb begin
    start = ctl_we && ctl_wdata.program_trigger_busy && program_arm &&
            !program_trigger_busy && program_mode_select != NVMBP_MODE_RSVD &&
            !rst;
    rd = ctl_we && ctl_wdata.read_strobe && !program_trigger_busy
         && !start;
  end

  // Programming sequencer; reset does not disturb it so work completes.
  always_comb begin
    next_state = state;
    next_tcnt = tcnt;
    mem_we = 1'b0;
    mem_wval = nvm_byte_data;
    case (state)
      NVMBP_IDLE: begin
        if (start) begin
          next_tcnt = op_time(program_mode_select);
          next_state = (program_mode_select == NVMBP_MODE_WRITE) ?
                       NVMBP_PROG : NVMBP_ERASE;
        end
      end
      NVMBP_ERASE, NVMBP_PROG: begin
        if (osc_tick) begin
          next_tcnt = tcnt - TW'(1);
        end
        if (tcnt == '0) begin
          mem_we = 1'b1;
          if (program_mode_select == NVMBP_MODE_ERASE) begin
            mem_wval = NVMBP_ERASED;
          end else if (program_mode_select == NVMBP_MODE_WRITE) begin
            mem_wval = mem[nvm_byte_address] & nvm_byte_data;
          end else begin
            mem_wval = nvm_byte_data;
          end
          next_state = NVMBP_IDLE;
        end
      end
      default: next_state = NVMBP_IDLE;
    endcase
  end

  // Register file next values.
  always_comb begin
    next_addr = nvm_byte_address;
    next_data = nvm_byte_data;
    next_mode = program_mode_select;
    next_arm_cnt = (arm_cnt != '0) ? arm_cnt - 3'h1 : 3'h0;
    next_stall_cnt = (stall_cnt != '0) ? stall_cnt - 3'h1 : 3'h0;
    if (addr_we && !program_trigger_busy) next_addr = addr_wdata;
    if (data_we) next_data = data_wdata;
    if (rd) begin
      next_data = mem[nvm_byte_address];
      next_stall_cnt = 3'(NVMBP_READ_STALL);
    end
    if (start) next_stall_cnt = 3'(NVMBP_WRITE_STALL);
    if (ctl_we && ctl_wdata.mode_we && !program_trigger_busy) begin
      next_mode = ctl_wdata.program_mode_select;
    end
    if (ctl_we && ctl_wdata.program_arm) begin
      next_arm_cnt = 3'(NVMBP_ARM_CYCLES);
    end
    if (rst) begin
      next_arm_cnt = 3'h0;
      next_stall_cnt = 3'h0;
      if (!program_trigger_busy) next_mode = NVMBP_MODE_ATOMIC;
    end
    next_arm = next_arm_cnt != 3'h0;
    next_busy = next_state != NVMBP_IDLE;
    next_stall = next_stall_cnt != 3'h0;
  end

  always_ff @(posedge clk) begin
    if (mem_we) mem[nvm_byte_address] <= mem_wval;
  end

  // Sequencer state survives reset so that programming completes.
  always_ff @(posedge clk) begin
    state <= next_state;
    tcnt <= next_tcnt;
    program_trigger_busy <= next_busy;
    nvm_byte_address <= next_addr;
    program_mode_select <= next_mode;
    if (rst && next_state == NVMBP_IDLE) begin
      state <= NVMBP_IDLE;
      program_trigger_busy <= 1'b0;
      nvm_byte_address <= NVMBP_ADDR_RST;
    end
  end

  always_ff @(posedge clk) begin
    arm_cnt <= next_arm_cnt;
    program_arm <= next_arm;
    stall_cnt <= next_stall_cnt;
    cpu_stall <= next_stall;
    // Data is kept while busy so an operation cut by reset stores it.
    nvm_byte_data <= (rst && !program_trigger_busy) ? NVMBP_DATA_RST :
                     next_data;
  end

  ////////////////////////////////////////////////////////////////////////////

  property p_arm_clears;
    @(posedge clk) disable iff (rst)
      ((ctl_we && ctl_wdata.program_arm) ##1
       !(ctl_we && ctl_wdata.program_arm) [*4]) |=> !program_arm;
  endproperty
  a_arm_clears: assert property (p_arm_clears)
    else $error("arm did not self clear after four cycles");

  property p_arm_holds;
    @(posedge clk) disable iff (rst)
      (ctl_we && ctl_wdata.program_arm) |=> program_arm [*4];
  endproperty
  a_arm_holds: assert property (p_arm_holds)
    else $error("arm window shorter than four cycles");

  property p_no_arm_no_start;
    @(posedge clk) disable iff (rst)
      (ctl_we && ctl_wdata.program_trigger_busy && !program_arm &&
       !program_trigger_busy) |=> !program_trigger_busy;
  endproperty
  a_no_arm_no_start: assert property (p_no_arm_no_start)
    else $error("trigger without arm started programming");

  property p_busy_split;
    @(posedge clk) disable iff (rst)
      (start && program_mode_select != NVMBP_MODE_ATOMIC)
        |=> program_trigger_busy [*8];
  endproperty
  a_busy_split: assert property (p_busy_split)
    else $error("busy dropped early in split operation");

  property p_busy_atomic;
    @(posedge clk) disable iff (rst)
      (start && program_mode_select == NVMBP_MODE_ATOMIC)
        |=> program_trigger_busy [*8];
  endproperty
  a_busy_atomic: assert property (p_busy_atomic)
    else $error("busy dropped early in atomic operation");

  property p_busy_clears_idle;
    @(posedge clk) disable iff (rst)
      $fell(program_trigger_busy) |-> $past(mem_we);
  endproperty
  a_busy_clears_idle: assert property (p_busy_clears_idle)
    else $error("busy without an operation");

  property p_read_blocked;
    @(posedge clk) disable iff (rst)
      (program_trigger_busy && ctl_we && ctl_wdata.read_strobe && !data_we)
        |=> $stable(nvm_byte_data) && !(stall_cnt > $past(stall_cnt));
  endproperty
  a_read_blocked: assert property (p_read_blocked)
    else $error("access accepted while busy");

  property p_mode_locked;
    @(posedge clk) disable iff (rst)
      program_trigger_busy && $past(program_trigger_busy)
        |-> $stable(program_mode_select);
  endproperty
  a_mode_locked: assert property (p_mode_locked)
    else $error("mode changed while busy");

  property p_read_stall;
    @(posedge clk) disable iff (rst)
      rd |=> cpu_stall [*4] ##1 !cpu_stall;
  endproperty
  a_read_stall: assert property (p_read_stall)
    else $error("read stall not four cycles");

  property p_tick_only;
    @(posedge clk) disable iff (rst)
      (state != NVMBP_IDLE && !osc_tick && tcnt != '0) |=> $stable(tcnt);
  endproperty
  a_tick_only: assert property (p_tick_only)
    else $error("timer moved without oscillator tick");

  property p_reset_keeps_busy;
    @(posedge clk) (rst && state != NVMBP_IDLE && tcnt != '0)
      |=> program_trigger_busy;
  endproperty
  a_reset_keeps_busy: assert property (p_reset_keeps_busy)
    else $error("reset aborted programming");

  c_erase: cover property (@(posedge clk) start &&
    program_mode_select == NVMBP_MODE_ERASE);
  c_write: cover property (@(posedge clk) start &&
    program_mode_select == NVMBP_MODE_WRITE);
  c_atomic: cover property (@(posedge clk) start &&
    program_mode_select == NVMBP_MODE_ATOMIC);
  c_read: cover property (@(posedge clk) rd);

endmodule : nvmbp_ctrl

//--- testbench/nvmbp_ctrl_tb.sv
/*
  Self-checking bench for the EEPROM programming controller.
  Assumes short oscillator and programming counts for simulation.
*/
module nvmbp_ctrl_tb;
  import nvmbp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int TS = 10;
  localparam int TA = 20;
  localparam int OD = 2;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic addr_we = 1'b0;
  logic data_we = 1'b0;
  logic ctl_we = 1'b0;
  logic [NVMBP_ADDR_W-1:0] addr_wdata = 7'h00;
  logic [NVMBP_DATA_W-1:0] data_wdata = 8'h00;
  nvmbp_ctl_wr_s ctl_wdata = 6'h00;
  logic [NVMBP_ADDR_W-1:0] nvm_byte_address;
  logic [NVMBP_DATA_W-1:0] nvm_byte_data;
  logic [1:0] program_mode_select;
  logic program_arm;
  logic program_trigger_busy;
  logic cpu_stall;
  int errors = 0;
  int checked = 0;
  int cyc = 0;
  int nb;
  int ns;

  ////////////////////////////////////////////////////////////////////////////
  nvmbp_ctrl #(.OSC_DIV(OD), .T_SPLIT(TS), .T_ATOMIC(TA)) u_nvmbp_ctrl (
    .clk(clk), .rst(rst), .addr_we(addr_we), .addr_wdata(addr_wdata),
    .data_we(data_we), .data_wdata(data_wdata), .ctl_we(ctl_we),
    .ctl_wdata(ctl_wdata), .nvm_byte_address(nvm_byte_address),
    .nvm_byte_data(nvm_byte_data), .program_mode_select(program_mode_select),
    .program_arm(program_arm), .program_trigger_busy(program_trigger_busy),
    .cpu_stall(cpu_stall));

  always #20 clk = ~clk;

  // wait_idle leaves a hung busy flag after 60 cycles; this caps the whole run at 3000.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // Control bits: read 20, trigger 10, arm 08, mode write 04, mode 03.
  task automatic put(input logic a, d, c, input logic [5:0] f);
    addr_we <= a;
    data_we <= d;
    ctl_we <= c;
    ctl_wdata <= nvmbp_ctl_wr_s'(f);
    @(posedge clk);
  endtask : put

  // Strobes drop here, never in the step in which a following put raises.
  task automatic quiet;
    addr_we <= 1'b0;
    data_we <= 1'b0;
    ctl_we <= 1'b0;
  endtask : quiet

  task automatic prog(input logic [1:0] m, input logic [6:0] a,
                      input logic [7:0] d);
    addr_wdata <= a;
    data_wdata <= d;
    put(1, 0, 0, 6'h00);
    put(0, 1, 0, 6'h00);
    put(0, 0, 1, {4'h3, m});
    put(0, 0, 1, {4'h4, m});
    quiet();
  endtask : prog

  task automatic wait_idle;
    nb = 0;
    ns = 0;
    repeat (60) begin
      @(negedge clk);
      if (cpu_stall === 1'b1) ns++;
      if (program_trigger_busy !== 1'b1) break;
      nb++;
    end
    @(posedge clk);
  endtask : wait_idle

  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    addr_wdata <= a;
    put(1, 0, 0, 6'h00);
    put(0, 0, 1, 6'h20);
    quiet();
    ns = 0;
    @(negedge clk);
    chk("read data", nvm_byte_data, e);
    repeat (6) begin
      if (cpu_stall === 1'b1) ns++;
      @(negedge clk);
    end
    chk("read stall", ns, 4);
    @(posedge clk);
  endtask : rd

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    @(negedge clk);
    chk("busy", program_trigger_busy, 0);
    chk("arm", program_arm, 0);
    chk("mode", program_mode_select, 0);
    chk("stall", cpu_stall, 0);
    @(posedge clk);
    $display("test reset done");
  endtask : t_reset

  task automatic t_split;
    prog(NVMBP_MODE_ATOMIC, 7'h05, 8'ha5);
    wait_idle();
    chk("atomic span", nb >= OD * TA && nb <= OD * TA + 2, 1);
    chk("trigger stall", ns, 2);
    rd(7'h05, 8'ha5);
    prog(NVMBP_MODE_ERASE, 7'h05, 8'h00);
    wait_idle();
    chk("erase span", nb >= OD * TS && nb <= OD * TS + 2, 1);
    rd(7'h05, NVMBP_ERASED);
    prog(NVMBP_MODE_WRITE, 7'h05, 8'h3c);
    wait_idle();
    chk("write span", nb >= OD * TS && nb <= OD * TS + 2, 1);
    rd(7'h05, 8'h3c);
    // Without an erase the old bits survive under the new ones.
    prog(NVMBP_MODE_WRITE, 7'h05, 8'h0f);
    wait_idle();
    rd(7'h05, 8'h0c);
    $display("test split modes done");
  endtask : t_split

  task automatic t_arm;
    put(0, 0, 1, 6'h10);
    quiet();
    @(negedge clk);
    chk("unarmed trigger", program_trigger_busy, 0);
    @(posedge clk);
    put(0, 0, 1, 6'h0c);
    quiet();
    nb = 0;
    repeat (8) begin
      @(negedge clk);
      if (program_arm === 1'b1) nb++;
    end
    chk("arm span", nb, 4);
    @(posedge clk);
    put(0, 0, 1, 6'h10);
    quiet();
    @(negedge clk);
    chk("late trigger", program_trigger_busy, 0);
    @(posedge clk);
    prog(NVMBP_MODE_RSVD, 7'h09, 8'h11);
    @(negedge clk);
    chk("reserved mode", program_trigger_busy, 0);
    @(posedge clk);
    $display("test arm window done");
  endtask : t_arm

  task automatic t_busy;
    prog(NVMBP_MODE_ERASE, 7'h05, 8'h00);
    @(posedge clk);
    addr_wdata <= 7'h22;
    put(1, 0, 0, 6'h00);
    put(0, 0, 1, 6'h07);
    put(0, 0, 1, 6'h20);
    quiet();
    @(negedge clk);
    chk("addr while busy", nvm_byte_address, 7'h05);
    chk("mode while busy", program_mode_select, 1);
    chk("read while busy", nvm_byte_data, 8'h00);
    chk("stall while busy", cpu_stall, 0);
    @(posedge clk);
    wait_idle();
    $display("test busy refusals done");
  endtask : t_busy

  task automatic t_rst;
    prog(NVMBP_MODE_ATOMIC, 7'h06, 8'h5a);
    repeat (3) @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("busy over reset", program_trigger_busy, 1);
    @(posedge clk);
    wait_idle();
    rd(7'h06, 8'h5a);
    $display("test reset in flight done");
  endtask : t_rst

  ////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_split();
    t_arm();
    t_busy();
    t_rst();
    results();
  end
endmodule : nvmbp_ctrl_tb
